// [verilog/cic_regs.sv]
// Our own choice: the address-and-strobe port.
`timescale 1ns/100ps
//
// Contract
// - X low, X high, Y low writes wait for Y high write and next blank.
// - Y high write takes effect at start of next vertical non-display period.
// - Colour 0 blue, five bits, read/write in bits 4 to 0.
// - Colour 0 green, six bits, read/write in bits 5 to 0.
// - Colour 0 red, five bits, read/write in bits 4 to 0.
// - Colour 1 blue, five bits, read/write in bits 4 to 0.
// - Colour 1 green, six bits, read/write in bits 5 to 0.
// - Colour 1 red, five bits, read/write in bits 4 to 0.
// - Four-bit FIFO threshold steers display memory request arbitration.
// - Threshold value zero makes hardware pick the threshold itself.
// - Two-bit mode: 00 inactive, 01 cursor, 10 ink, 11 reserved.
module cic_regs #(
    parameter logic [3:0] AUTO_THRESH = cic_pkg::THR_AUTO
) (
    // Clock and reset
    input  wire logic         i_clock,
    input  wire logic         i_rst,
    // Register port
    input  wire logic [7:0]   i_addr,
    input  wire logic [7:0]   i_wdata,
    input  wire logic         i_wr,
    input  wire logic         i_rd,
    output logic [7:0]        o_rdata,
    // Display timing
    input  wire logic         i_vndp,
    // Layer control
    output logic [1:0]        o_mode,
    output logic              o_cursor_en,
    output logic              o_ink_en,
    // Cursor position
    output cic_pkg::cic_pos_t o_pos_x,
    output cic_pkg::cic_pos_t o_pos_y,
    output logic              o_pos_pending,
    // Colours
    output cic_pkg::cic_color_t o_color0,
    output cic_pkg::cic_color_t o_color1,
    // Memory request threshold
    output logic [3:0]        o_fifo_thresh,
    output logic              o_thresh_auto
);

    logic              vndp_r;
    logic              vstart;
    logic              wr_yhi;
    logic [3:0]        thresh_r;
    logic [7:0]        rdata_nxt;
    cic_pkg::cic_pos_t shadow_x_r;
    cic_pkg::cic_pos_t shadow_y_r;

    // Write decodes
    function automatic logic hit(input logic [7:0] ofs);
        hit = i_wr && (i_addr == ofs);
    endfunction

    assign wr_yhi = hit(cic_pkg::OFS_POS_YHI);

    // Start of vertical non-display period
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            vndp_r <= 1'b0;
        end else begin
            vndp_r <= i_vndp;
        end
    end

    assign vstart = i_vndp && !vndp_r;

    // Mode selector and decoded enables
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_mode      <= cic_pkg::RST_MODE;
            o_cursor_en <= 1'b0;
            o_ink_en    <= 1'b0;
        end else if (hit(cic_pkg::OFS_MODE)) begin
            o_mode      <= i_wdata[cic_pkg::MODE_MSB:0];
            o_cursor_en <= (i_wdata[cic_pkg::MODE_MSB:0] == cic_pkg::MODE_CURSOR);
            o_ink_en    <= (i_wdata[cic_pkg::MODE_MSB:0] == cic_pkg::MODE_INK);
        end
    end

    // Held position values
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            shadow_x_r <= cic_pkg::RST_POS;
            shadow_y_r <= cic_pkg::RST_POS;
        end else begin
            if (hit(cic_pkg::OFS_POS_XLO)) begin
                shadow_x_r.mag[7:0] <= i_wdata;
            end
            if (hit(cic_pkg::OFS_POS_XHI)) begin
                shadow_x_r.mag[9:8] <= i_wdata[cic_pkg::POS_HI_MSB:0];
                shadow_x_r.sign     <= i_wdata[cic_pkg::POS_SIGN_BIT];
            end
            if (hit(cic_pkg::OFS_POS_YLO)) begin
                shadow_y_r.mag[7:0] <= i_wdata;
            end
            if (wr_yhi) begin
                shadow_y_r.mag[9:8] <= i_wdata[cic_pkg::POS_HI_MSB:0];
                shadow_y_r.sign     <= i_wdata[cic_pkg::POS_SIGN_BIT];
            end
        end
    end

    cic_pos_commit u_commit (
        .i_clock    (i_clock),
        .i_rst      (i_rst),
        .i_arm      (wr_yhi),
        .i_vstart   (vstart),
        .i_shadow_x (shadow_x_r),
        .i_shadow_y (shadow_y_r),
        .o_pos_x    (o_pos_x),
        .o_pos_y    (o_pos_y),
        .o_pending  (o_pos_pending)
    );

    // Colour 0
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_color0 <= cic_pkg::RST_COLOR;
        end else begin
            if (hit(cic_pkg::OFS_C0_BLUE)) begin
                o_color0.blue <= i_wdata[cic_pkg::RB_MSB:0];
            end
            if (hit(cic_pkg::OFS_C0_GREEN)) begin
                o_color0.green <= i_wdata[cic_pkg::G_MSB:0];
            end
            if (hit(cic_pkg::OFS_C0_RED)) begin
                o_color0.red <= i_wdata[cic_pkg::RB_MSB:0];
            end
        end
    end

    // Colour 1
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_color1 <= cic_pkg::RST_COLOR;
        end else begin
            if (hit(cic_pkg::OFS_C1_BLUE)) begin
                o_color1.blue <= i_wdata[cic_pkg::RB_MSB:0];
            end
            if (hit(cic_pkg::OFS_C1_GREEN)) begin
                o_color1.green <= i_wdata[cic_pkg::G_MSB:0];
            end
            if (hit(cic_pkg::OFS_C1_RED)) begin
                o_color1.red <= i_wdata[cic_pkg::RB_MSB:0];
            end
        end
    end

    // Threshold register
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            thresh_r <= cic_pkg::RST_THR;
        end else if (hit(cic_pkg::OFS_FIFO_THR)) begin
            thresh_r <= i_wdata[cic_pkg::THR_MSB:0];
        end
    end

    cic_thresh_sel #(
        .AUTO_VALUE (AUTO_THRESH)
    ) u_thresh (
        .i_clock      (i_clock),
        .i_rst        (i_rst),
        .i_thresh_raw (thresh_r),
        .o_thresh     (o_fifo_thresh),
        .o_auto       (o_thresh_auto)
    );

    // Read multiplexer, unused bits zero
    always_comb begin
        rdata_nxt = 8'h00;
        case (i_addr)
            cic_pkg::OFS_MODE:     rdata_nxt = {6'h00, o_mode};
            cic_pkg::OFS_POS_XLO:  rdata_nxt = shadow_x_r.mag[7:0];
            cic_pkg::OFS_POS_XHI:  rdata_nxt = {shadow_x_r.sign, 5'h00, shadow_x_r.mag[9:8]};
            cic_pkg::OFS_POS_YLO:  rdata_nxt = shadow_y_r.mag[7:0];
            cic_pkg::OFS_POS_YHI:  rdata_nxt = {shadow_y_r.sign, 5'h00, shadow_y_r.mag[9:8]};
            cic_pkg::OFS_C0_BLUE:  rdata_nxt = {3'h0, o_color0.blue};
            cic_pkg::OFS_C0_GREEN: rdata_nxt = {2'h0, o_color0.green};
            cic_pkg::OFS_C0_RED:   rdata_nxt = {3'h0, o_color0.red};
            cic_pkg::OFS_C1_BLUE:  rdata_nxt = {3'h0, o_color1.blue};
            cic_pkg::OFS_C1_GREEN: rdata_nxt = {2'h0, o_color1.green};
            cic_pkg::OFS_C1_RED:   rdata_nxt = {3'h0, o_color1.red};
            cic_pkg::OFS_FIFO_THR: rdata_nxt = {4'h0, thresh_r};
            default:               rdata_nxt = 8'h00;
        endcase
    end

    // Read data valid in the cycle after the strobe
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= cic_pkg::RST_RDATA;
        end else if (i_rd) begin
            o_rdata <= rdata_nxt;
        end else begin
            o_rdata <= cic_pkg::RST_RDATA;
        end
    end

    // Checks
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_rst);

    chk_pending_arm: assert property (
        wr_yhi |=> o_pos_pending
    ) else $error("pending not set after Y high write");

    chk_pos_hold: assert property (
        ($changed(o_pos_x) || $changed(o_pos_y)) |-> $past(vstart && o_pos_pending && !wr_yhi)
    ) else $error("position changed outside commit");

    chk_pos_apply: assert property (
        (vstart && o_pos_pending && !wr_yhi) |=> (o_pos_y == $past(shadow_y_r)) && !o_pos_pending
    ) else $error("position not applied at blank start");

    chk_pos_wait: assert property (
        (wr_yhi && !vstart) ##1 (!vstart && !wr_yhi) [*2] |=> $stable(o_pos_y)
    ) else $error("position applied before blank");

    chk_c0_blue: assert property (
        (i_wr && (i_addr == cic_pkg::OFS_C0_BLUE)) |=> o_color0.blue == $past(i_wdata[4:0])
    ) else $error("colour 0 blue not stored");

    chk_c0_green: assert property (
        (i_wr && (i_addr == cic_pkg::OFS_C0_GREEN)) |=> o_color0.green == $past(i_wdata[5:0])
    ) else $error("colour 0 green not stored");

    chk_c0_red: assert property (
        (i_wr && (i_addr == cic_pkg::OFS_C0_RED)) |=> o_color0.red == $past(i_wdata[4:0])
    ) else $error("colour 0 red not stored");

    chk_c1_blue: assert property (
        (i_wr && (i_addr == cic_pkg::OFS_C1_BLUE)) |=> o_color1.blue == $past(i_wdata[4:0])
    ) else $error("colour 1 blue not stored");

    chk_c1_green: assert property (
        (i_wr && (i_addr == cic_pkg::OFS_C1_GREEN)) |=> o_color1.green == $past(i_wdata[5:0])
    ) else $error("colour 1 green not stored");

    chk_c1_red: assert property (
        (i_wr && (i_addr == cic_pkg::OFS_C1_RED)) |=> o_color1.red == $past(i_wdata[4:0])
    ) else $error("colour 1 red not stored");

    chk_thresh_prog: assert property (
        (i_wr && (i_addr == cic_pkg::OFS_FIFO_THR) && (i_wdata[3:0] != 4'h0))
            |=> ##1 o_fifo_thresh == $past(i_wdata[3:0], 2)
    ) else $error("programmed threshold not used");

    chk_thresh_auto: assert property (
        (thresh_r == 4'h0) |=> (o_fifo_thresh == AUTO_THRESH) && o_thresh_auto
    ) else $error("automatic threshold not used");

    chk_mode_decode: assert property (
        (o_cursor_en == (o_mode == cic_pkg::MODE_CURSOR)) && (o_ink_en == (o_mode == cic_pkg::MODE_INK))
    ) else $error("mode enables disagree with mode");

    chk_upper_zero: assert property (
        (i_rd && (i_addr == cic_pkg::OFS_C1_GREEN)) |=> o_rdata[7:6] == 2'h0
    ) else $error("unused colour bits not zero");

    chk_c0_blue_read: assert property (
        (i_rd && (i_addr == cic_pkg::OFS_C0_BLUE)) |=> o_rdata == {3'h0, $past(o_color0.blue)}
    ) else $error("colour 0 blue readback wrong");

    chk_c0_green_read: assert property (
        (i_rd && (i_addr == cic_pkg::OFS_C0_GREEN)) |=> o_rdata == {2'h0, $past(o_color0.green)}
    ) else $error("colour 0 green readback wrong");

    chk_c0_red_read: assert property (
        (i_rd && (i_addr == cic_pkg::OFS_C0_RED)) |=> o_rdata == {3'h0, $past(o_color0.red)}
    ) else $error("colour 0 red readback wrong");

    chk_c1_blue_read: assert property (
        (i_rd && (i_addr == cic_pkg::OFS_C1_BLUE)) |=> o_rdata == {3'h0, $past(o_color1.blue)}
    ) else $error("colour 1 blue readback wrong");

    chk_c1_green_read: assert property (
        (i_rd && (i_addr == cic_pkg::OFS_C1_GREEN)) |=> o_rdata == {2'h0, $past(o_color1.green)}
    ) else $error("colour 1 green readback wrong");

    chk_c1_red_read: assert property (
        (i_rd && (i_addr == cic_pkg::OFS_C1_RED)) |=> o_rdata == {3'h0, $past(o_color1.red)}
    ) else $error("colour 1 red readback wrong");

    chk_thresh_read: assert property (
        (i_rd && (i_addr == cic_pkg::OFS_FIFO_THR)) |=> o_rdata == {4'h0, $past(thresh_r)}
    ) else $error("threshold readback wrong");

    chk_mode_read: assert property (
        (i_rd && (i_addr == cic_pkg::OFS_MODE)) |=> o_rdata == {6'h00, $past(o_mode)}
    ) else $error("mode readback wrong");

    chk_mode_store: assert property (
        (i_wr && (i_addr == cic_pkg::OFS_MODE)) |=> o_mode == $past(i_wdata[1:0])
    ) else $error("mode not stored");

    chk_mode_reserved: assert property (
        (o_mode == cic_pkg::MODE_RSVD) |-> !o_cursor_en && !o_ink_en
    ) else $error("reserved mode enables a layer");

    chk_thresh_write: assert property (
        (i_wr && (i_addr == cic_pkg::OFS_FIFO_THR)) |=> thresh_r == $past(i_wdata[3:0])
    ) else $error("threshold not stored");

    chk_thresh_follow: assert property (
        (thresh_r != 4'h0) |=> !o_thresh_auto && (o_fifo_thresh == $past(thresh_r))
    ) else $error("nonzero threshold not followed");

    chk_rdata_idle: assert property (
        !i_rd |=> o_rdata == 8'h00
    ) else $error("read data not zero when idle");

    chk_unmapped_zero: assert property (
        (i_rd && ((i_addr == 8'h89) || (i_addr == 8'h8D) || (i_addr == 8'h8F))) |=> o_rdata == 8'h00
    ) else $error("unmapped address not read as zero");

    chk_xlo_read: assert property (
        (i_rd && (i_addr == cic_pkg::OFS_POS_XLO)) |=> o_rdata == $past(shadow_x_r.mag[7:0])
    ) else $error("held X low not read back");

    chk_pending_hold: assert property (
        (o_pos_pending && !vstart) |=> o_pos_pending
    ) else $error("pending dropped before blank");

    chk_posx_apply: assert property (
        (vstart && o_pos_pending && !wr_yhi) |=> o_pos_x == $past(shadow_x_r)
    ) else $error("X position not applied at blank start");

    chk_arm_wins: assert property (
        (wr_yhi && vstart) |=> o_pos_pending && $stable(o_pos_x) && $stable(o_pos_y)
    ) else $error("Y high write at blank start committed early");

    cov_commit: cover property (wr_yhi ##[1:50] (vstart && o_pos_pending));
    cov_arm_blank: cover property (wr_yhi && vstart);
    cov_reserved: cover property (o_mode == cic_pkg::MODE_RSVD);
    cov_auto: cover property (o_thresh_auto ##1 !o_thresh_auto);
    cov_ink: cover property (o_ink_en ##1 o_cursor_en);

endmodule

// [verilog/cic_pkg.sv]
package cic_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_MODE      = 8'h80;
    localparam logic [7:0] OFS_POS_XLO   = 8'h82;
    localparam logic [7:0] OFS_POS_XHI   = 8'h83;
    localparam logic [7:0] OFS_POS_YLO   = 8'h84;
    localparam logic [7:0] OFS_POS_YHI   = 8'h85;
    localparam logic [7:0] OFS_C0_BLUE   = 8'h86;
    localparam logic [7:0] OFS_C0_GREEN  = 8'h87;
    localparam logic [7:0] OFS_C0_RED    = 8'h88;
    localparam logic [7:0] OFS_C1_BLUE   = 8'h8A;
    localparam logic [7:0] OFS_C1_GREEN  = 8'h8B;
    localparam logic [7:0] OFS_C1_RED    = 8'h8C;
    localparam logic [7:0] OFS_FIFO_THR  = 8'h8E;

    // Field positions
    localparam int POS_SIGN_BIT  = 7;
    localparam int POS_HI_MSB    = 1;
    localparam int RB_MSB        = 4;
    localparam int G_MSB         = 5;
    localparam int THR_MSB       = 3;
    localparam int MODE_MSB      = 1;

    // Values after reset
    localparam logic [1:0] RST_MODE      = 2'h0;
    localparam logic [4:0] RST_RB        = 5'h00;
    localparam logic [5:0] RST_G         = 6'h00;
    localparam logic [3:0] RST_THR       = 4'h0;
    localparam logic [7:0] RST_RDATA     = 8'h00;

    // Threshold chosen by hardware when programmed value is zero
    localparam logic [3:0] THR_AUTO      = 4'h8;
    localparam logic [3:0] THR_ZERO      = 4'h0;

    // Mode selector codes
    localparam logic [1:0] MODE_OFF      = 2'h0;
    localparam logic [1:0] MODE_CURSOR   = 2'h1;
    localparam logic [1:0] MODE_INK      = 2'h2;
    localparam logic [1:0] MODE_RSVD     = 2'h3;

    typedef struct packed {
        logic       sign;
        logic [9:0] mag;
    } cic_pos_t;

    typedef struct packed {
        logic [4:0] red;
        logic [5:0] green;
        logic [4:0] blue;
    } cic_color_t;

    localparam cic_pos_t   RST_POS   = '{sign: 1'b0, mag: 10'h000};
    localparam cic_color_t RST_COLOR = '{red: 5'h00, green: 6'h00, blue: 5'h00};

endpackage

// [verilog/cic_pos_commit.sv]
`timescale 1ns/100ps
module cic_pos_commit (
    // Clock and reset
    input  wire logic              i_clock,
    input  wire logic              i_rst,
    // Control
    input  wire logic              i_arm,
    input  wire logic              i_vstart,
    input  wire cic_pkg::cic_pos_t i_shadow_x,
    input  wire cic_pkg::cic_pos_t i_shadow_y,
    // Applied values
    output cic_pkg::cic_pos_t      o_pos_x,
    output cic_pkg::cic_pos_t      o_pos_y,
    output logic                   o_pending
);

    // Pending flag, a new arm wins over the clear
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_pending <= 1'b0;
        end else if (i_arm) begin
            o_pending <= 1'b1;
        end else if (i_vstart) begin
            o_pending <= 1'b0;
        end
    end

    // Apply held values at start of non-display period
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_pos_x <= cic_pkg::RST_POS;
            o_pos_y <= cic_pkg::RST_POS;
        end else if (i_vstart && o_pending && !i_arm) begin
            o_pos_x <= i_shadow_x;
            o_pos_y <= i_shadow_y;
        end
    end

endmodule

// [verilog/cic_thresh_sel.sv]
`timescale 1ns/100ps
module cic_thresh_sel #(
    parameter logic [3:0] AUTO_VALUE = cic_pkg::THR_AUTO
) (
    // Clock and reset
    input  wire logic       i_clock,
    input  wire logic       i_rst,
    // Programmed value
    input  wire logic [3:0] i_thresh_raw,
    // Effective value
    output logic [3:0]      o_thresh,
    output logic            o_auto
);

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_thresh <= AUTO_VALUE;
            o_auto   <= 1'b1;
        end else if (i_thresh_raw == cic_pkg::THR_ZERO) begin
            o_thresh <= AUTO_VALUE;
            o_auto   <= 1'b1;
        end else begin
            o_thresh <= i_thresh_raw;
            o_auto   <= 1'b0;
        end
    end

endmodule

// [sim/crt_ink_cursor_regs_bench.sv]
`timescale 1ns/100ps
module crt_ink_cursor_regs_bench;

    logic                i_clock;
    logic                i_rst;
    logic [7:0]          i_addr;
    logic [7:0]          i_wdata;
    logic                i_wr;
    logic                i_rd;
    logic [7:0]          o_rdata;
    logic                i_vndp;
    logic [1:0]          o_mode;
    logic                o_cursor_en;
    logic                o_ink_en;
    cic_pkg::cic_pos_t   o_pos_x;
    cic_pkg::cic_pos_t   o_pos_y;
    logic                o_pos_pending;
    cic_pkg::cic_color_t o_color0;
    cic_pkg::cic_color_t o_color1;
    logic [3:0]          o_fifo_thresh;
    logic                o_thresh_auto;
    int                  err_total;
    int                  n_compared;
    logic [7:0]          rdv;
    // Address, write data, expected readback
    logic [23:0]         rows [0:10] = '{24'h86FF1F, 24'h87FF3F, 24'h88FF1F, 24'h8AEA0A, 24'h8BD515,
                                         24'h8C3515, 24'h8EF505, 24'h81FF00, 24'h89FF00, 24'h8DFF00,
                                         24'h8FFF00};

    cic_regs u_dut (
        .i_clock       (i_clock),
        .i_rst         (i_rst),
        .i_addr        (i_addr),
        .i_wdata       (i_wdata),
        .i_wr          (i_wr),
        .i_rd          (i_rd),
        .o_rdata       (o_rdata),
        .i_vndp        (i_vndp),
        .o_mode        (o_mode),
        .o_cursor_en   (o_cursor_en),
        .o_ink_en      (o_ink_en),
        .o_pos_x       (o_pos_x),
        .o_pos_y       (o_pos_y),
        .o_pos_pending (o_pos_pending),
        .o_color0      (o_color0),
        .o_color1      (o_color1),
        .o_fifo_thresh (o_fifo_thresh),
        .o_thresh_auto (o_thresh_auto)
    );

    initial begin
        i_clock = 1'b0;
        forever #20 i_clock = ~i_clock;
    end

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clock);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_clock);
        i_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clock);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_clock);
        i_rd   <= 1'b0;
        #1 d = o_rdata;
    endtask

    task automatic edges(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask

    task automatic chk_rst();
        chk("mode", 16'(o_mode), 16'h0000);
        chk("enables", 16'({o_cursor_en, o_ink_en}), 16'h0000);
        chk("pos_x", 16'(o_pos_x), 16'h0000);
        chk("pos_y", 16'(o_pos_y), 16'h0000);
        chk("pending", 16'(o_pos_pending), 16'h0000);
        chk("color0", 16'(o_color0), 16'h0000);
        chk("color1", 16'(o_color1), 16'h0000);
        chk("thresh", 16'(o_fifo_thresh), 16'(cic_pkg::THR_AUTO));
        chk("auto", 16'(o_thresh_auto), 16'h0001);
    endtask

    // Watchdog
    initial begin
        repeat (5000) @(posedge i_clock);
        err_total++;
        stop_test();
    end

    initial begin
        err_total  = 0;
        n_compared = 0;
        i_rst      = 1'b1;
        i_addr     = 8'h00;
        i_wdata    = 8'h00;
        i_wr       = 1'b0;
        i_rd       = 1'b0;
        i_vndp     = 1'b0;
        repeat (20) @(posedge i_clock);
        i_rst <= 1'b0;
        #1 chk_rst();
        $display("reset test done");
        // Register rows
        for (int k = 0; k < 11; k++) begin
            wr(rows[k][23:16], rows[k][15:8]);
            rd(rows[k][23:16], rdv);
            chk("readback", 16'(rdv), 16'(rows[k][7:0]));
        end
        edges(1);
        chk("rdata idle", 16'(o_rdata), 16'h0000);
        chk("color0", 16'(o_color0), {5'h1F, 6'h3F, 5'h1F});
        chk("color1", 16'(o_color1), {5'h15, 6'h15, 5'h0A});
        chk("thresh", 16'(o_fifo_thresh), 16'h0005);
        chk("auto", 16'(o_thresh_auto), 16'h0000);
        $display("register table test done");
        // Threshold boundaries
        wr(8'h8E, 8'h00);
        edges(2);
        chk("thresh", 16'(o_fifo_thresh), 16'(cic_pkg::THR_AUTO));
        chk("auto", 16'(o_thresh_auto), 16'h0001);
        wr(8'h8E, 8'h0F);
        edges(2);
        chk("thresh", 16'(o_fifo_thresh), 16'h000F);
        chk("auto", 16'(o_thresh_auto), 16'h0000);
        $display("threshold test done");
        // Every mode code
        for (int m = 0; m < 4; m++) begin
            wr(cic_pkg::OFS_MODE, 8'(m));
            edges(2);
            chk("mode", 16'(o_mode), 16'(m));
            chk("cursor_en", 16'(o_cursor_en), 16'(m == 1));
            chk("ink_en", 16'(o_ink_en), 16'(m == 2));
        end
        $display("mode test done");
        // Position writes alone stay held through a blank
        wr(8'h82, 8'h3F);
        wr(8'h83, 8'h80);
        wr(8'h84, 8'h34);
        rd(cic_pkg::OFS_POS_XLO, rdv);
        chk("xlo readback", 16'(rdv), 16'h003F);
        @(posedge i_clock);
        i_vndp <= 1'b1;
        edges(3);
        chk("pending", 16'(o_pos_pending), 16'h0000);
        chk("pos_x", 16'(o_pos_x), 16'h0000);
        @(posedge i_clock);
        i_vndp <= 1'b0;
        wr(8'h85, 8'h02);
        edges(3);
        chk("pending", 16'(o_pos_pending), 16'h0001);
        chk("pos_y", 16'(o_pos_y), 16'h0000);
        @(posedge i_clock);
        i_vndp <= 1'b1;
        edges(2);
        chk("pos_x", 16'(o_pos_x), 16'h043F);
        chk("pos_y", 16'(o_pos_y), 16'h0234);
        chk("pending", 16'(o_pos_pending), 16'h0000);
        @(posedge i_clock);
        i_vndp <= 1'b0;
        // Y high write in the blank start cycle waits for the next blank
        wr(8'h82, 8'h05);
        wr(8'h85, 8'h01);
        @(posedge i_clock);
        i_wr    <= 1'b1;
        i_addr  <= 8'h85;
        i_wdata <= 8'h01;
        i_vndp  <= 1'b1;
        @(posedge i_clock);
        i_wr <= 1'b0;
        edges(3);
        chk("pending", 16'(o_pos_pending), 16'h0001);
        chk("pos_x", 16'(o_pos_x), 16'h043F);
        @(posedge i_clock);
        i_vndp <= 1'b0;
        @(posedge i_clock);
        i_vndp <= 1'b1;
        edges(2);
        chk("pos_x", 16'(o_pos_x), 16'h0405);
        chk("pos_y", 16'(o_pos_y), 16'h0134);
        chk("pending", 16'(o_pos_pending), 16'h0000);
        @(posedge i_clock);
        i_vndp <= 1'b0;
        $display("position test done");
        // Second reset mid-run
        @(posedge i_clock);
        i_rst <= 1'b1;
        edges(2);
        chk_rst();
        @(posedge i_clock);
        i_rst <= 1'b0;
        rd(cic_pkg::OFS_C0_GREEN, rdv);
        chk("readback", 16'(rdv), 16'h0000);
        $display("second reset test done");
        stop_test();
    end

endmodule
